// *** common/spims_pkg.sv ***
package spims_pkg;

    // ------------------------------------------------------------------
    // Data path sizes.
    // ------------------------------------------------------------------
    localparam int unsigned DATA_W = 8;
    localparam int unsigned EDGE_CNT_W = 4;
    localparam logic [3:0] EDGE_FIRST = 4'h0;
    localparam logic [3:0] EDGE_LAST = 4'hF;

    // ------------------------------------------------------------------
    // Bit-rate divider field widths.
    // ------------------------------------------------------------------
    localparam int unsigned PRESCALE_W = 3;
    localparam int unsigned RATE_W = 3;

    // ------------------------------------------------------------------
    // Reset values.
    // ------------------------------------------------------------------
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic TX_EMPTY_RST = 1'b1;
    localparam logic PIN_RELEASED = 1'b1;
    localparam logic SELECT_IDLE = 1'b1;

    // ------------------------------------------------------------------
    // Transfer states.
    // ------------------------------------------------------------------
    typedef enum logic [0:0] {
        ST_IDLE,
        ST_RUN
    } spims_state_e;

endpackage : spims_pkg

// *** hdl/spims_port.sv ***
// Functional notes
// RULE1 - Master starts transfers; shifters exchange contents.
// RULE2 - Serial clock: output as master, input slave.
// RULE3 - External master holds select low for transfer.
// RULE4 - Written byte waits, loads at transfer start.
// RULE5 - Received byte moves into separate receive buffer.
// RULE6 - Master: clock out, data out MOSI, in MISO.
// RULE7 - Slave: clock in, data out MISO, in MOSI.
// RULE8 - Prescale divides bus clock by one to eight.
// RULE9 - Rate field divides further by two to 256.
// RULE10 - Port disabled releases all four pins.
// RULE11 - Single-wire master: MOSI shared, enable sets direction.
// RULE12 - Single-wire slave: MOSI released to general use.
// RULE13 - Single-wire slave: MISO shared, enable sets direction.
// RULE14 - Single-wire master: MISO released to general use.
// RULE15 - Slave: select pin always active-low select input.
// RULE16 - Master without fault enable releases select pin.
// RULE17 - Master with fault enable: fault input or select output.
// RULE18 - Polarity chooses clock idle low or high.
// RULE19 - Phase chooses first edge mid or start bit.
// RULE20 - Bit order: MSB first or LSB first.
// RULE21 - Disable aborts, empties buffers, resets flags.
// RULE22 - Low fault input sets fault, drops mastership.
// RULE23 - Receive-full on buffer fill, transmit-empty on load.
`timescale 1ns/1ps
module spims_port (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic PORT_ENABLE_I,
    input wire logic MASTER_ROLE_SELECT_I,
    input wire logic CLOCK_IDLE_POLARITY_I,
    input wire logic CLOCK_EDGE_PHASE_I,
    input wire logic LOW_BIT_FIRST_I,
    input wire logic SINGLE_WIRE_SELECT_I,
    input wire logic SHARED_PIN_OUTPUT_ENABLE_I,
    input wire logic MODE_FAULT_ENABLE_I,
    input wire logic SELECT_OUTPUT_ENABLE_I,
    input wire logic [2:0] PRESCALE_FIELD_I,
    input wire logic [2:0] RATE_SELECT_FIELD_I,
    input wire logic DATA_WR_I,
    input wire logic [7:0] DATA_WDATA_I,
    input wire logic DATA_RD_I,
    input wire logic MODE_FAULT_CLR_I,
    output logic [7:0] DATA_RDATA_O,
    output logic RECEIVE_FULL_FLAG_O,
    output logic TRANSMIT_EMPTY_FLAG_O,
    output logic MODE_FAULT_FLAG_O,
    output logic BUSY_O,
    input wire logic SCK_I,
    output logic SCK_O,
    output logic SCK_OE_N_O,
    output logic SCK_OWN_O,
    input wire logic MOSI_I,
    output logic MOSI_O,
    output logic MOSI_OE_N_O,
    output logic MOSI_OWN_O,
    input wire logic MISO_I,
    output logic MISO_O,
    output logic MISO_OE_N_O,
    output logic MISO_OWN_O,
    input wire logic SS_N_I,
    output logic SS_O,
    output logic SS_OE_N_O,
    output logic SS_OWN_O
);

    typedef struct packed {
        spims_pkg::spims_state_e st;
        logic [7:0] tx_buf;
        logic tx_empty;
        logic [7:0] rx_buf;
        logic rx_full;
        logic [7:0] shift;
        logic [3:0] edges;
        logic sck_lvl;
        logic sck_prev;
        logic sel_prev;
        logic mode_fault_flag;
        logic busy;
        logic dout;
        logic sck_o, sck_oe_n, sck_own;
        logic mosi_o, mosi_oe_n, mosi_own;
        logic miso_o, miso_oe_n, miso_own;
        logic ss_o, ss_oe_n, ss_own;
    } spims_core_s;

    spims_core_s core_reg;
    spims_core_s core_next;
    logic tick;
    logic load;
    logic done;
    logic is_master;
    logic din;
    logic lvl_in;
    logic ev_lead;
    logic ev_trail;
    logic sel;

    // ------------------------------------------------------------------
    // Helpers.
    // ------------------------------------------------------------------
    function automatic spims_core_s core_reset();
        spims_core_s r;
        r = '0;
        r.st = spims_pkg::ST_IDLE;
        r.tx_buf = spims_pkg::DATA_RST;
        r.rx_buf = spims_pkg::DATA_RST;
        r.tx_empty = spims_pkg::TX_EMPTY_RST;
        r.sck_oe_n = spims_pkg::PIN_RELEASED;
        r.mosi_oe_n = spims_pkg::PIN_RELEASED;
        r.miso_oe_n = spims_pkg::PIN_RELEASED;
        r.ss_oe_n = spims_pkg::PIN_RELEASED;
        r.ss_o = spims_pkg::SELECT_IDLE;
        return r;
    endfunction : core_reset

    function automatic logic out_bit(input logic [7:0] s, input logic lsbf);
        return lsbf ? s[0] : s[7]; // RULE20
    endfunction : out_bit

    function automatic logic [7:0] shift_in(input logic [7:0] s, input logic b, input logic lsbf);
        return lsbf ? {b, s[7:1]} : {s[6:0], b}; // RULE20
    endfunction : shift_in

    spims_rate_div #(
        .PRE_W(spims_pkg::PRESCALE_W),
        .RATE_W(spims_pkg::RATE_W)
    ) u_div (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .run_i(PORT_ENABLE_I && is_master && core_reg.st == spims_pkg::ST_RUN),
        .prescale_i(PRESCALE_FIELD_I),
        .rate_i(RATE_SELECT_FIELD_I),
        .tick_o(tick)
    );

    // ------------------------------------------------------------------
    // Transfer engine and pin routing.
    // ------------------------------------------------------------------
    always_comb begin
        core_next = core_reg;
        load = 1'b0;
        done = 1'b0;
        ev_lead = 1'b0;
        ev_trail = 1'b0;
        is_master = MASTER_ROLE_SELECT_I && !core_reg.mode_fault_flag; // RULE22
        sel = !SS_N_I; // RULE15
        lvl_in = SCK_I ^ CLOCK_IDLE_POLARITY_I; // RULE18
        if (is_master) begin
            din = SINGLE_WIRE_SELECT_I ? MOSI_I : MISO_I; // RULE6 RULE11
        end else begin
            din = SINGLE_WIRE_SELECT_I ? MISO_I : MOSI_I; // RULE7 RULE13
        end
        if (!PORT_ENABLE_I) begin
            core_next = core_reset(); // RULE10 RULE21
        end else begin
            core_next.sck_prev = lvl_in;
            core_next.sel_prev = sel;
            if (is_master) begin
                if (core_reg.st == spims_pkg::ST_IDLE && !core_reg.tx_empty) begin
                    load = 1'b1; // RULE1
                end else if (core_reg.st == spims_pkg::ST_RUN && tick) begin
                    core_next.sck_lvl = !core_reg.sck_lvl; // RULE2
                    ev_lead = !core_reg.sck_lvl;
                    ev_trail = core_reg.sck_lvl;
                end
            end else if (!sel) begin
                core_next.st = spims_pkg::ST_IDLE; // RULE3
                core_next.edges = spims_pkg::EDGE_FIRST;
            end else begin
                ev_lead = lvl_in && !core_reg.sck_prev; // RULE2
                ev_trail = !lvl_in && core_reg.sck_prev;
                if (core_reg.st == spims_pkg::ST_IDLE) begin
                    if (!CLOCK_EDGE_PHASE_I && !core_reg.sel_prev) begin
                        load = 1'b1; // RULE19
                    end else if (CLOCK_EDGE_PHASE_I && ev_lead) begin
                        load = 1'b1; // RULE19
                    end
                    ev_trail = 1'b0;
                    if (!load) begin
                        ev_lead = 1'b0;
                    end
                end
            end
            if (load) begin
                core_next.shift = core_reg.tx_buf; // RULE4
                core_next.dout = out_bit(core_reg.tx_buf, LOW_BIT_FIRST_I);
                core_next.tx_empty = 1'b1; // RULE23
                core_next.st = spims_pkg::ST_RUN;
                core_next.edges = spims_pkg::EDGE_FIRST;
                core_next.sck_lvl = 1'b0;
                if (!is_master) begin
                    ev_lead = 1'b0;
                end
            end
            if (load && !is_master && CLOCK_EDGE_PHASE_I) begin
                core_next.edges = spims_pkg::EDGE_FIRST + 4'h1;
            end else if (core_reg.st == spims_pkg::ST_RUN && (ev_lead || ev_trail)) begin
                if (CLOCK_EDGE_PHASE_I ? ev_trail : ev_lead) begin // RULE19
                    core_next.shift = shift_in(core_reg.shift, din, LOW_BIT_FIRST_I); // RULE1
                end else begin
                    core_next.dout = out_bit(core_reg.shift, LOW_BIT_FIRST_I);
                end
                core_next.edges = core_reg.edges + 4'h1;
                if (core_reg.edges == spims_pkg::EDGE_LAST) begin
                    done = 1'b1;
                    core_next.st = spims_pkg::ST_IDLE;
                    core_next.sck_lvl = 1'b0;
                end
            end
            if (DATA_RD_I) begin
                core_next.rx_full = 1'b0;
            end
            if (done) begin
                core_next.rx_buf = core_next.shift; // RULE5
                core_next.rx_full = 1'b1; // RULE23
            end
            if (DATA_WR_I) begin
                core_next.tx_buf = DATA_WDATA_I; // RULE4
                core_next.tx_empty = 1'b0;
            end
            if (MODE_FAULT_CLR_I) begin
                core_next.mode_fault_flag = 1'b0;
            end
            if (is_master && MODE_FAULT_ENABLE_I && !SELECT_OUTPUT_ENABLE_I && sel) begin
                core_next.mode_fault_flag = 1'b1; // RULE22
                core_next.st = spims_pkg::ST_IDLE;
                core_next.sck_lvl = 1'b0;
            end
            core_next.busy = core_next.st == spims_pkg::ST_RUN;
            core_next.sck_own = 1'b1;
            core_next.sck_oe_n = !is_master; // RULE2
            core_next.sck_o = core_next.sck_lvl ^ CLOCK_IDLE_POLARITY_I; // RULE18
            core_next.mosi_o = core_next.dout;
            core_next.miso_o = core_next.dout;
            if (is_master) begin
                core_next.mosi_own = 1'b1; // RULE6 RULE11
                core_next.mosi_oe_n = SINGLE_WIRE_SELECT_I && !SHARED_PIN_OUTPUT_ENABLE_I;
                core_next.miso_own = !SINGLE_WIRE_SELECT_I; // RULE14
                core_next.miso_oe_n = 1'b1;
                core_next.ss_own = MODE_FAULT_ENABLE_I; // RULE16 RULE17
                core_next.ss_oe_n = !(MODE_FAULT_ENABLE_I && SELECT_OUTPUT_ENABLE_I);
                core_next.ss_o = !core_next.busy;
            end else begin
                core_next.mosi_own = !SINGLE_WIRE_SELECT_I; // RULE12
                core_next.mosi_oe_n = 1'b1;
                core_next.miso_own = 1'b1; // RULE7 RULE13
                core_next.miso_oe_n = !sel || (SINGLE_WIRE_SELECT_I && !SHARED_PIN_OUTPUT_ENABLE_I);
                core_next.ss_own = 1'b1; // RULE15
                core_next.ss_oe_n = 1'b1;
                core_next.ss_o = spims_pkg::SELECT_IDLE;
            end
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            core_reg <= core_reset();
        end else begin
            core_reg <= core_next;
        end
    end

    assign DATA_RDATA_O = core_reg.rx_buf;
    assign RECEIVE_FULL_FLAG_O = core_reg.rx_full;
    assign TRANSMIT_EMPTY_FLAG_O = core_reg.tx_empty;
    assign MODE_FAULT_FLAG_O = core_reg.mode_fault_flag;
    assign BUSY_O = core_reg.busy;
    assign SCK_O = core_reg.sck_o;
    assign SCK_OE_N_O = core_reg.sck_oe_n;
    assign SCK_OWN_O = core_reg.sck_own;
    assign MOSI_O = core_reg.mosi_o;
    assign MOSI_OE_N_O = core_reg.mosi_oe_n;
    assign MOSI_OWN_O = core_reg.mosi_own;
    assign MISO_O = core_reg.miso_o;
    assign MISO_OE_N_O = core_reg.miso_oe_n;
    assign MISO_OWN_O = core_reg.miso_own;
    assign SS_O = core_reg.ss_o;
    assign SS_OE_N_O = core_reg.ss_oe_n;
    assign SS_OWN_O = core_reg.ss_own;

    // ------------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------------
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (RST_I);

    a_disable_clears: assert property (!PORT_ENABLE_I |=> // RULE21
        !RECEIVE_FULL_FLAG_O && TRANSMIT_EMPTY_FLAG_O && !BUSY_O)
        else $error("disable did not clear the port");
    a_off_pins_free: assert property (!PORT_ENABLE_I |=> // RULE10
        !SCK_OWN_O && !MOSI_OWN_O && !MISO_OWN_O && !SS_OWN_O && SCK_OE_N_O)
        else $error("disabled port still holds a pin");
    a_rx_capture: assert property (done |=> // RULE5
        RECEIVE_FULL_FLAG_O && DATA_RDATA_O == $past(core_next.shift))
        else $error("received byte not captured");
    a_tx_load_empty: assert property ((load && !DATA_WR_I) |=> // RULE23
        TRANSMIT_EMPTY_FLAG_O && BUSY_O)
        else $error("load did not empty the buffer");
    a_master_route: assert property ( // RULE6
        (PORT_ENABLE_I && is_master && !SINGLE_WIRE_SELECT_I) |=>
        !SCK_OE_N_O && !MOSI_OE_N_O && MISO_OE_N_O)
        else $error("master pin routing wrong");
    a_slave_route: assert property ( // RULE7
        (PORT_ENABLE_I && !MASTER_ROLE_SELECT_I && !SINGLE_WIRE_SELECT_I && !SS_N_I) |=>
        SCK_OE_N_O && MOSI_OE_N_O && !MISO_OE_N_O)
        else $error("slave pin routing wrong");
    a_bidir_master: assert property ( // RULE11
        (PORT_ENABLE_I && is_master && SINGLE_WIRE_SELECT_I) |=>
        MOSI_OE_N_O == !$past(SHARED_PIN_OUTPUT_ENABLE_I) && !MISO_OWN_O)
        else $error("single-wire master pins wrong");
    a_bidir_slave: assert property ( // RULE13
        (PORT_ENABLE_I && !MASTER_ROLE_SELECT_I && SINGLE_WIRE_SELECT_I && !SS_N_I) |=>
        !MOSI_OWN_O && MISO_OE_N_O == !$past(SHARED_PIN_OUTPUT_ENABLE_I))
        else $error("single-wire slave pins wrong");
    a_fault_sets: assert property ((PORT_ENABLE_I && is_master && MODE_FAULT_ENABLE_I // RULE22
        && !SELECT_OUTPUT_ENABLE_I && !SS_N_I) |=> MODE_FAULT_FLAG_O && !BUSY_O)
        else $error("mode fault not raised");
    a_ss_release: assert property ( // RULE16
        (PORT_ENABLE_I && is_master && !MODE_FAULT_ENABLE_I) |=>
        !SS_OWN_O && SS_OE_N_O)
        else $error("select pin not released");
    a_idle_level: assert property ((PORT_ENABLE_I && is_master && !core_next.busy) |=> // RULE18
        SCK_O == $past(CLOCK_IDLE_POLARITY_I))
        else $error("serial clock idle level wrong");

    c_master_byte: cover property (is_master && done);
    c_slave_byte: cover property (!MASTER_ROLE_SELECT_I && done);
    c_mode_fault: cover property ($rose(MODE_FAULT_FLAG_O));
    c_lsb_phase: cover property (done && LOW_BIT_FIRST_I && CLOCK_EDGE_PHASE_I);

endmodule : spims_port

// *** hdl/spims_rate_div.sv ***
`timescale 1ns/1ps
module spims_rate_div #(
    parameter int unsigned PRE_W = spims_pkg::PRESCALE_W,
    parameter int unsigned RATE_W = spims_pkg::RATE_W
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    input wire logic [PRE_W-1:0] prescale_i,
    input wire logic [RATE_W-1:0] rate_i,
    output logic tick_o
);

    localparam int unsigned CNT_W = (1 << RATE_W) - 1;

    if (PRE_W < 1 || PRE_W > 4 || RATE_W < 1 || RATE_W > 4) begin : g_check
        $error("spims_rate_div: field widths must lie between 1 and 4");
    end

    typedef struct packed {
        logic [PRE_W-1:0] pre_cnt;
        logic [CNT_W-1:0] rate_cnt;
        logic tick;
    } spims_div_s;

    spims_div_s div_reg;
    spims_div_s div_next;
    logic [CNT_W-1:0] rate_lim;

    // ------------------------------------------------------------------
    // Tick every (prescale + 1) * 2^rate cycles, which is half a bit.
    // ------------------------------------------------------------------
    always_comb begin
        rate_lim = CNT_W'(({{CNT_W{1'b0}}, 1'b1} << rate_i) - 1'b1);
        div_next = div_reg;
        div_next.tick = 1'b0;
        if (!run_i) begin
            div_next = '0;
        end else if (div_reg.pre_cnt == prescale_i) begin // RULE8
            div_next.pre_cnt = '0;
            if (div_reg.rate_cnt == rate_lim) begin // RULE9
                div_next.rate_cnt = '0;
                div_next.tick = 1'b1;
            end else begin
                div_next.rate_cnt = div_reg.rate_cnt + 1'b1;
            end
        end else begin
            div_next.pre_cnt = div_reg.pre_cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_next;
        end
    end

    assign tick_o = div_reg.tick;

    // ------------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------------
    logic [15:0] gap_reg;
    logic cfg_mod_reg;
    logic [15:0] half_period;

    always_comb begin
        half_period = 16'((32'(prescale_i) + 32'h1) << rate_i);
    end

    // The gap count starts one below zero so the first tick of a run lands on the same count.
    always_ff @(posedge clk_i) begin
        if (rst_i || !run_i) begin
            gap_reg <= 16'hFFFF;
            cfg_mod_reg <= 1'b0;
        end else if (tick_o) begin
            gap_reg <= 16'h0000;
            cfg_mod_reg <= 1'b0;
        end else begin
            gap_reg <= gap_reg + 16'h0001;
            if (prescale_i != $past(prescale_i) || rate_i != $past(rate_i)) begin
                cfg_mod_reg <= 1'b1;
            end
        end
    end

    a_tick_spacing: assert property (@(posedge clk_i) disable iff (rst_i) // RULE9
        (tick_o && run_i && $past(run_i) && !cfg_mod_reg) |-> (gap_reg == half_period - 16'h0001))
        else $error("divider tick spacing wrong");

endmodule : spims_rate_div

// *** test/spims_far_slave.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Serial slave device on the far side of the port.
// ------------------------------------------------------------------
module spims_far_slave (
    input wire logic sck_i,
    input wire logic mosi_i,
    input wire logic ss_n_i,
    input wire logic clock_idle_polarity_i,
    input wire logic clock_edge_phase_i,
    input wire logic lsb_i,
    input wire logic [7:0] tx_i,
    output logic miso_o,
    output logic [7:0] rx_o
);
    logic [3:0] n_reg = 4'h0;
    logic out_reg = 1'b0;
    logic sel_reg = 1'b0;

    function automatic int pos(input logic [3:0] n);
        return lsb_i ? int'(n[2:0]) : 7 - int'(n[2:0]);
    endfunction : pos

    // Deselected, the line shows the inverse of the last bit so stale data never matches.
    assign miso_o = ss_n_i ? ~out_reg : out_reg;
    always @(negedge ss_n_i) begin
        n_reg = 4'h0;
        out_reg = tx_i[pos(4'h0)];
    end
    // The select level is taken a step late so a clock edge in the deselect step still counts.
    always @(ss_n_i) begin
        sel_reg <= !ss_n_i;
    end
    always @(sck_i) begin
        if (sel_reg) begin
            if ((sck_i ^ clock_idle_polarity_i ^ clock_edge_phase_i) == 1'b1) begin
                rx_o[pos(n_reg)] = mosi_i;
                n_reg = n_reg + 4'h1;
            end else begin
                out_reg = tx_i[pos(n_reg)];
            end
        end
    end
endmodule : spims_far_slave

// *** test/test_spims_port.sv ***
`timescale 1ns/1ps
module test_spims_port;
    logic clk = 1'b0, rst = 1'b1, en = 1'b0, ms = 1'b0, clock_idle_polarity = 1'b0, clock_edge_phase = 1'b0, lsb = 1'b0;
    logic sw = 1'b0, shoe = 1'b0, mf = 1'b0, so = 1'b0, wr = 1'b0, rd = 1'b0, mclr = 1'b0;
    logic sck_in = 1'b0, mosi_in = 1'b0, ss_in = 1'b1;
    logic [2:0] pre = 3'h0, rate = 3'h0;
    logic [7:0] wdata = 8'h00, ptx = 8'h00, prx, rdata, sg, pins;
    logic rxf, txe, mode_fault_flag, busy, miso_p;
    logic sck_o, sck_oen, sck_own, mosi_o, mosi_oen, mosi_own;
    logic miso_o, miso_oen, miso_own, ss_o, ss_oen, ss_own;
    int error_cnt = 0;
    int checks = 0;
    int n, h;

    spims_port uut (.CLK_I(clk), .RST_I(rst), .PORT_ENABLE_I(en), .MASTER_ROLE_SELECT_I(ms),
        .CLOCK_IDLE_POLARITY_I(clock_idle_polarity), .CLOCK_EDGE_PHASE_I(clock_edge_phase), .LOW_BIT_FIRST_I(lsb),
        .SINGLE_WIRE_SELECT_I(sw), .SHARED_PIN_OUTPUT_ENABLE_I(shoe), .MODE_FAULT_ENABLE_I(mf),
        .SELECT_OUTPUT_ENABLE_I(so), .PRESCALE_FIELD_I(pre), .RATE_SELECT_FIELD_I(rate),
        .DATA_WR_I(wr), .DATA_WDATA_I(wdata), .DATA_RD_I(rd), .MODE_FAULT_CLR_I(mclr),
        .DATA_RDATA_O(rdata), .RECEIVE_FULL_FLAG_O(rxf), .TRANSMIT_EMPTY_FLAG_O(txe),
        .MODE_FAULT_FLAG_O(mode_fault_flag), .BUSY_O(busy), .SCK_I(sck_in), .SCK_O(sck_o),
        .SCK_OE_N_O(sck_oen), .SCK_OWN_O(sck_own), .MOSI_I(mosi_in), .MOSI_O(mosi_o),
        .MOSI_OE_N_O(mosi_oen), .MOSI_OWN_O(mosi_own), .MISO_I(miso_p), .MISO_O(miso_o),
        .MISO_OE_N_O(miso_oen), .MISO_OWN_O(miso_own), .SS_N_I(ss_in), .SS_O(ss_o),
        .SS_OE_N_O(ss_oen), .SS_OWN_O(ss_own));

    spims_far_slave far (.sck_i(sck_o), .mosi_i(mosi_o), .ss_n_i(ss_o), .clock_idle_polarity_i(clock_idle_polarity),
        .clock_edge_phase_i(clock_edge_phase), .lsb_i(lsb), .tx_i(ptx), .miso_o(miso_p), .rx_o(prx));

    // ------------------------------------------------------------------
    // Shared tasks.
    // ------------------------------------------------------------------
    task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task cyc(input int k);
        repeat (k) @(negedge clk);
    endtask : cyc

    task write(input logic [7:0] d);
        wr = 1'b1;
        wdata = d;
        cyc(1);
        wr = 1'b0;
    endtask : write

    task pulse_rd;
        rd = 1'b1;
        cyc(1);
        rd = 1'b0;
        cyc(1);
    endtask : pulse_rd

    // Waits for a transfer to start, then counts the cycles it stays busy.
    task wait_done(output int cnt);
        cnt = 0;
        for (int i = 0; i < 8 && busy !== 1'b1; i++) cyc(1);
        while (busy === 1'b1 && cnt < 40000) begin
            cyc(1);
            cnt++;
        end
    endtask : wait_done

    task close_out;
        $display("checks=%0d error_cnt=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : close_out

    // ------------------------------------------------------------------
    // Clock, watchdog and test sequence.
    // ------------------------------------------------------------------
    initial begin
        forever #12.5 clk = ~clk;
    end

    initial begin
        repeat (95000) @(posedge clk);
        error_cnt++;
        close_out();
    end

    initial begin
        cyc(3);
        rst = 1'b0;
        cyc(2);
        chk({rxf, txe, mode_fault_flag, busy}, 8'h04, "reset flags");
        chk({sck_own, mosi_own, miso_own, ss_own}, 8'h00, "disabled pins");
        en = 1'b1;
        ms = 1'b1;
        mf = 1'b1;
        so = 1'b1;
        for (int m = 0; m < 8; m++) begin
            {clock_idle_polarity, clock_edge_phase, lsb} = m[2:0];
            pre = m[2:0];
            rate = m[2:0];
            ptx = 8'h3C + m[7:0];
            cyc(3);
            chk(sck_o, clock_idle_polarity, "idle clock");
            write(8'hA5 ^ m[7:0]);
            wait_done(n);
            h = (m + 1) << m;
            chk(n >= 16 * h && n <= 16 * h + 2, 8'h01, "busy length");
            cyc(1);
            chk(rdata, ptx, "master receive");
            chk(prx, 8'hA5 ^ m[7:0], "far receive");
            chk({rxf, txe}, 8'h03, "flags after byte");
            pulse_rd();
            chk(rxf, 8'h00, "read clears full");
        end
        {clock_idle_polarity, clock_edge_phase, lsb, pre, rate} = 9'h000;
        write(8'h11);
        cyc(3);
        chk(txe, 8'h01, "buffer loaded");
        write(8'h22);
        chk(txe, 8'h00, "buffer held");
        wait_done(n);
        chk(rdata, ptx, "first of two");
        wait_done(n);
        chk(prx, 8'h22, "second of two");
        write(8'h5A);
        cyc(5);
        en = 1'b0;
        cyc(2);
        chk({busy, txe, rxf, sck_own}, 8'h04, "abort by disable");
        en = 1'b1;
        for (int i = 0; i < 32; i++) begin
            {ms, sw, shoe, mf, so} = i[4:0];
            cyc(3);
            pins = {sck_own, mosi_own, miso_own, ss_own, sck_oen, mosi_oen, miso_oen, ss_oen};
            sg = {1'b1, ms | ~sw, ~ms | ~sw, ~ms | mf, ~ms, ~(ms & (~sw | shoe)), 1'b1,
                ~(ms & mf & so)};
            chk(pins[7:4], sg[7:4], "pin owners");
            chk(pins[3:0], sg[3:0], "pin drives");
        end
        {ms, sw, shoe, mf, so} = 5'h12;
        cyc(2);
        ss_in = 1'b0;
        cyc(1);
        ss_in = 1'b1;
        cyc(3);
        chk({mode_fault_flag, sck_oen}, 8'h03, "mode fault");
        mclr = 1'b1;
        cyc(1);
        mclr = 1'b0;
        cyc(1);
        chk(mode_fault_flag, 8'h00, "fault cleared");
        {ms, sw, shoe, mf, so} = 5'h00;
        write(8'h96);
        ss_in = 1'b0;
        cyc(4);
        chk(miso_oen, 0, "slave drives");
        for (int b = 7; b >= 0; b--) begin
            mosi_in = 1'(8'hC3 >> b);
            cyc(4);
            sg[b] = miso_o;
            sck_in = 1'b1;
            cyc(4);
            sck_in = 1'b0;
        end
        cyc(4);
        ss_in = 1'b1;
        cyc(4);
        chk(sg, 8'h96, "slave send");
        chk(rdata, 8'hC3, "slave receive");
        chk(rxf, 8'h01, "slave full");
        close_out();
    end
endmodule : test_spims_port
